// file: hw/cfd_top.sv
// Purpose: Decode configuration words into static controls
// Assumes: APB slave, zero wait states, 20 MHz sys_clk
// Notes:   Words written over APB take effect at the next reset
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Stack limit set: option bits 6 and 7 read 1, stack two deep.
// - Stack limit clear: option bits 6 and 7 writable, stack eight deep.
// - Carry input on: add gives dest plus work plus carry.
// - Carry input on: subtract gives dest minus work minus not-carry.
// - Carry input off: add and subtract ignore the carry flag.
// - Brown-out code 11 disables; other codes enable chosen threshold.
// - Memory code picks pages and banks: 1/1, 1/2, 4/4, 4/8.
// - Synchroniser bit 0 adds two flops on port inputs; 1 bypasses.
// - Internal oscillator bit 0 selects RC; 1 uses external type.
// - Divider code sets instruction rate: 4M, 125k, 1M, 31.25k Hz.
// - Three-bit trim drives RC oscillator, 000 slowest, 111 fastest.
// - Crystal buffer bit turns the crystal buffer off or on.
// - Protection bit 0 scrambles readback of configuration words.
// - External type codes 000 to 110 select crystal drive modes.
// - External type 111 selects RC network, no clock on output pin.
module cfd_top #(
    parameter int PORT_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              por_n,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [PORT_W-1:0] port_in,
    output logic      [PORT_W-1:0] port_in_sync,
    input  wire logic [7:0]        alu_dest,
    input  wire logic [7:0]        alu_work,
    input  wire logic              alu_carry,
    input  wire logic              alu_sub,
    output logic      [7:0]        alu_result,
    output logic                   alu_carry_out,
    output logic                   timer_readback_select,
    output logic                   timer_edge_irq_enable,
    output logic      [3:0]        stack_depth,
    output logic      [2:0]        prog_pages,
    output logic      [3:0]        data_banks,
    output logic                   brownout_on,
    output logic      [1:0]        brownout_level_sel,
    output logic      [1:0]        brownout_trim,
    output logic                   int_osc_on,
    output logic      [1:0]        int_osc_divider,
    output logic      [2:0]        int_osc_trim,
    output logic                   instr_tick,
    output logic      [2:0]        ext_osc_type,
    output logic                   ext_osc_rc,
    output logic                   osc_out_clock_on,
    output logic                   crystal_buffer_on,
    output logic                   read_scramble_on,
    output logic                   watchdog_on,
    output logic                   carry_in_disable,
    output logic                   insync_on
);

    ////////////////////////////////////////////////////////////////////
    // Stored words and latched copies
    logic [11:0] config_word_main;
    logic [11:0] config_word_ext;
    logic [11:0] active_main;
    logic [11:0] active_ext;
    logic [7:0]  option_value;
    logic        option_stack_limit;
    logic        wr_main;
    logic        wr_ext;
    logic        wr_opt;

    // Stored words model nonvolatile cells: only power-on resets them to defaults
    always_ff @(posedge sys_clk) begin
        if (!por_n) begin
            config_word_main <= cfd_pkg::MAIN_DEFAULT;
            config_word_ext  <= cfd_pkg::EXT_DEFAULT;
        end else begin
            if (wr_main) begin
                config_word_main <= pwdata[11:0];
            end
            if (wr_ext) begin
                config_word_ext <= pwdata[11:0];
            end
        end
    end

    // Copy taken during reset; writes after release wait for next reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            active_main <= config_word_main;
            active_ext  <= config_word_ext;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Field decode
    assign option_stack_limit = active_ext[cfd_pkg::EXT_STACK_LIM];
    assign carry_in_disable   = active_ext[cfd_pkg::EXT_CARRY_DIS];
    assign brownout_level_sel =
        active_ext[cfd_pkg::EXT_BOR_LSB +: 2];
    assign brownout_trim      = active_ext[cfd_pkg::EXT_BTRIM_LSB +: 2];
    assign brownout_on        =
        brownout_level_sel != cfd_pkg::BOR_OFF;
    assign int_osc_trim       = {active_ext[cfd_pkg::EXT_TRIM2],
        active_ext[cfd_pkg::EXT_TRIM_LSB +: 2]};
    assign crystal_buffer_on  =
        active_main[cfd_pkg::MAIN_XTAL_BUF];
    assign insync_on          = !active_main[cfd_pkg::MAIN_SYNC_BYP];
    assign int_osc_on         =
        !active_main[cfd_pkg::MAIN_IOSC_N];
    assign read_scramble_on   = !active_main[cfd_pkg::MAIN_SCRAM_N];
    assign int_osc_divider    = active_main[cfd_pkg::MAIN_DIV_LSB +: 2];
    assign watchdog_on        = active_main[cfd_pkg::MAIN_WDOG];
    // Drive mode only means something with the RC oscillator off
    assign ext_osc_type       = int_osc_on ? 3'h0
        : active_main[cfd_pkg::MAIN_EXT_LSB +: 3];
    assign ext_osc_rc         = ext_osc_type == cfd_pkg::EXT_RC;
    assign osc_out_clock_on   = !int_osc_on && !ext_osc_rc;
    assign stack_depth        = option_stack_limit
        ? cfd_pkg::STACK_SHORT : cfd_pkg::STACK_LONG;

    // Memory size table
    always_comb begin
        unique case (active_ext[cfd_pkg::EXT_MEM_LSB +: 2])
            2'h0: begin
                prog_pages = 3'h1;
                data_banks = 4'h1;
            end
            2'h1: begin
                prog_pages = 3'h1;
                data_banks = 4'h2;
            end
            2'h2: begin
                prog_pages = 3'h4;
                data_banks = 4'h4;
            end
            2'h3: begin
                prog_pages = 3'h4;
                data_banks = 4'h8;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Option register with lockable top bits
    logic [7:0] next_option;

    assign next_option = option_stack_limit
        ? (pwdata[7:0] | 8'hC0) : pwdata[7:0];
    assign timer_readback_select = option_value[cfd_pkg::OPT_READBACK];
    assign timer_edge_irq_enable = option_value[cfd_pkg::OPT_EDGE_IRQ];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            option_value <= cfd_pkg::OPT_DEFAULT;
        end else if (wr_opt) begin
            option_value <= next_option;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave: read data captured in setup, answered with no wait
    logic        setup;
    logic        access;
    logic        hit_main;
    logic        hit_ext;
    logic        hit_opt;
    logic        hit_stat;
    logic        hit;
    logic [11:0] rd_main;
    logic [11:0] rd_ext;
    logic [31:0] status_word;
    logic [31:0] next_prdata;

    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign hit_main = paddr == cfd_pkg::OFS_WORD_MAIN;
    assign hit_ext  = paddr == cfd_pkg::OFS_WORD_EXT;
    assign hit_opt  = paddr == cfd_pkg::OFS_OPTION;
    assign hit_stat = paddr == cfd_pkg::OFS_STATUS;
    assign hit      = hit_main || hit_ext || hit_opt || hit_stat;
    assign wr_main  = access && pwrite && hit_main;
    assign wr_ext   = access && pwrite && hit_ext;
    assign wr_opt   = access && pwrite && hit_opt;
    assign pready   = 1'b1;
    assign pslverr  = access && !hit;

    // Protected words read back scrambled
    assign rd_main = read_scramble_on
        ? cfd_pkg::cfd_scramble(config_word_main)
        : config_word_main;
    assign rd_ext  = read_scramble_on
        ? cfd_pkg::cfd_scramble(config_word_ext)
        : config_word_ext;
    assign status_word = {20'h0, stack_depth, data_banks,
                          1'b0, prog_pages};
    assign next_prdata =
        hit_main ? {20'h0, rd_main} :
        hit_ext  ? {20'h0, rd_ext} :
        hit_opt  ? {24'h0, option_value} :
        hit_stat ? status_word : 32'h0;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (setup) begin
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Instruction clock from internal oscillator divider
    logic [9:0] div_cnt;
    logic [9:0] next_div_cnt;

    assign next_div_cnt = div_cnt == 10'h0
        ? cfd_pkg::cfd_ratio(int_osc_divider) - 10'h1
        : div_cnt - 10'h1;

    // External clock source runs the core every system cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_cnt    <= 10'h0;
            instr_tick <= 1'b0;
        end else if (int_osc_on) begin
            div_cnt    <= next_div_cnt;
            instr_tick <= div_cnt == 10'h0;
        end else begin
            div_cnt    <= 10'h0;
            instr_tick <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Add/subtract unit and input synchroniser
    cfd_alu_if alu_bus ();

    assign alu_bus.dest      = alu_dest;
    assign alu_bus.work      = alu_work;
    assign alu_bus.carry     = alu_carry;
    assign alu_bus.is_sub    = alu_sub;
    assign alu_bus.carry_dis = carry_in_disable;

    cfd_alu u_alu (
        .bus (alu_bus.alu)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            alu_result    <= 8'h00;
            alu_carry_out <= 1'b0;
        end else begin
            alu_result    <= alu_bus.result;
            alu_carry_out <= alu_bus.carry_out;
        end
    end

    cfd_insync #(
        .PORT_W (PORT_W)
    ) u_insync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .bypass  (!insync_on),
        .pin_in  (port_in),
        .pin_out (port_in_sync)
    );

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_opt_locked;
        @(posedge sys_clk) disable iff (!rst_n)
        ($past(rst_n) && option_stack_limit && $past(wr_opt))
            |-> option_value[7:6] == 2'h3 && stack_depth == 4'h2;
    endproperty
    a_opt_locked: assert property (p_opt_locked)
        else $error("locked option bits or short stack wrong");

    property p_opt_free;
        @(posedge sys_clk) disable iff (!rst_n)
        (!option_stack_limit && wr_opt)
            |=> option_value == $past(pwdata[7:0]) && stack_depth == 4'h8;
    endproperty
    a_opt_free: assert property (p_opt_free)
        else $error("option write not taken as written");

    property p_add_carry;
        @(posedge sys_clk) disable iff (!rst_n)
        (!carry_in_disable && !alu_sub)
            |=> alu_result == 8'($past(alu_dest) + $past(alu_work)
                + {7'h0, $past(alu_carry)});
    endproperty
    a_add_carry: assert property (p_add_carry)
        else $error("add did not include carry");

    property p_sub_carry;
        @(posedge sys_clk) disable iff (!rst_n)
        (!carry_in_disable && alu_sub)
            |=> alu_result == 8'($past(alu_dest) - $past(alu_work)
                - {7'h0, !$past(alu_carry)});
    endproperty
    a_sub_carry: assert property (p_sub_carry)
        else $error("subtract did not remove not-carry");

    property p_no_carry;
        @(posedge sys_clk) disable iff (!rst_n)
        carry_in_disable |=> alu_result == ($past(alu_sub)
            ? 8'($past(alu_dest) - $past(alu_work))
            : 8'($past(alu_dest) + $past(alu_work)));
    endproperty
    a_no_carry: assert property (p_no_carry)
        else $error("carry used while disabled");

    property p_bor;
        @(posedge sys_clk) disable iff (!rst_n)
        brownout_on == (active_ext[5:4] != 2'h3);
    endproperty
    a_bor: assert property (p_bor)
        else $error("brown-out enable mismatch");

    property p_mem;
        @(posedge sys_clk) disable iff (!rst_n)
        (active_ext[1:0] == 2'h3) |-> prog_pages == 3'h4
            && data_banks == 4'h8;
    endproperty
    a_mem: assert property (p_mem)
        else $error("default memory size wrong");

    property p_tick;
        @(posedge sys_clk) disable iff (!rst_n)
        (int_osc_on && int_osc_divider == 2'h0 && instr_tick)
            |=> !instr_tick [*4] ##1 instr_tick;
    endproperty
    a_tick: assert property (p_tick)
        else $error("4 MHz instruction tick spacing wrong");

    property p_rc_out;
        @(posedge sys_clk) disable iff (!rst_n)
        (!int_osc_on && active_main[2:0] == 3'h7) |-> !osc_out_clock_on;
    endproperty
    a_rc_out: assert property (p_rc_out)
        else $error("clock out driven in RC mode");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n) |-> $stable(active_main) && $stable(active_ext);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latched configuration changed while running");

    property p_scramble;
        @(posedge sys_clk) disable iff (!rst_n)
        (read_scramble_on && setup && hit_main)
            |=> prdata[11:0] != $past(config_word_main)
             || config_word_main == cfd_pkg::cfd_scramble(config_word_main);
    endproperty
    a_scramble: assert property (p_scramble)
        else $error("protected word read back in clear");

endmodule : cfd_top
`default_nettype wire

// file: inc/cfd_pkg.sv
// Purpose: Constants for the configuration word decoder
// Assumes: 20 MHz system clock, 12-bit configuration words
// Notes:   APB byte offsets, field positions, defaults
package cfd_pkg;

    ////////////////////////////////////////////////////////////////////
    // APB register byte offsets
    localparam logic [7:0] OFS_WORD_MAIN = 8'h00;
    localparam logic [7:0] OFS_WORD_EXT  = 8'h04;
    localparam logic [7:0] OFS_OPTION    = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0C;

    ////////////////////////////////////////////////////////////////////
    // Main word fields
    localparam int MAIN_XTAL_BUF  = 9;
    localparam int MAIN_SYNC_BYP  = 8;
    localparam int MAIN_IOSC_N    = 7;
    localparam int MAIN_SCRAM_N   = 6;
    localparam int MAIN_DIV_LSB   = 4;
    localparam int MAIN_WDOG      = 3;
    localparam int MAIN_EXT_LSB   = 0;
    // Extension word fields, then option register bits
    localparam int EXT_TRIM2      = 11;
    localparam int EXT_STACK_LIM  = 10;
    localparam int EXT_TRIM_LSB   = 8;
    localparam int EXT_CARRY_DIS  = 6;
    localparam int EXT_BOR_LSB    = 4;
    localparam int EXT_BTRIM_LSB  = 2;
    localparam int EXT_MEM_LSB    = 0;
    localparam int OPT_READBACK   = 6;
    localparam int OPT_EDGE_IRQ   = 7;

    ////////////////////////////////////////////////////////////////////
    // Reset values and codes
    localparam logic [11:0] MAIN_DEFAULT = 12'h140;
    localparam logic [11:0] EXT_DEFAULT  = 12'h473;
    localparam logic [7:0]  OPT_DEFAULT  = 8'hFF;
    localparam logic [11:0] SCRAM_KEY    = 12'hA5C;
    localparam logic [1:0]  BOR_OFF      = 2'h3;
    localparam logic [2:0]  EXT_RC       = 3'h7;
    localparam logic [3:0]  STACK_SHORT  = 4'h2;
    localparam logic [3:0]  STACK_LONG   = 4'h8;

    ////////////////////////////////////////////////////////////////////
    // Instruction clock rates from the internal oscillator
    localparam int SYS_CLK_HZ   = 20_000_000;
    localparam int IOSC_HZ_DIV0 = 4_000_000;
    localparam int IOSC_HZ_DIV1 = 125_000;
    localparam int IOSC_HZ_DIV2 = 1_000_000;
    localparam int IOSC_HZ_DIV3 = 31_250;
    localparam logic [9:0] RATIO0 = 10'(SYS_CLK_HZ / IOSC_HZ_DIV0);
    localparam logic [9:0] RATIO1 = 10'(SYS_CLK_HZ / IOSC_HZ_DIV1);
    localparam logic [9:0] RATIO2 = 10'(SYS_CLK_HZ / IOSC_HZ_DIV2);
    localparam logic [9:0] RATIO3 = 10'(SYS_CLK_HZ / IOSC_HZ_DIV3);

    // System clocks per instruction clock
    function automatic logic [9:0] cfd_ratio(input logic [1:0] div);
        unique case (div)
            2'h0: cfd_ratio = RATIO0;
            2'h1: cfd_ratio = RATIO1;
            2'h2: cfd_ratio = RATIO2;
            2'h3: cfd_ratio = RATIO3;
        endcase
    endfunction : cfd_ratio

    // Rotate then mask, so a protected word never reads back as stored
    function automatic logic [11:0] cfd_scramble(input logic [11:0] w);
        cfd_scramble = {w[5:0], w[11:6]} ^ SCRAM_KEY;
    endfunction : cfd_scramble

endpackage : cfd_pkg

// file: inc/cfd_alu_if.sv
// Purpose: Operand and result bundle for the add/subtract unit
// Assumes: 8-bit data path
// Notes:   Purely combinational bundle
`timescale 1ns/10ps
`default_nettype none
interface cfd_alu_if;
    logic [7:0] dest;
    logic [7:0] work;
    logic       carry;
    logic       is_sub;
    logic       carry_dis;
    logic [7:0] result;
    logic       carry_out;
    modport user (output dest, work, carry, is_sub, carry_dis,
                  input result, carry_out);
    modport alu (input dest, work, carry, is_sub, carry_dis,
                 output result, carry_out);
endinterface : cfd_alu_if
`default_nettype wire

// file: hw/cfd_alu.sv
// Purpose: Add and subtract with configurable carry input
// Assumes: Carry out on subtract means no borrow
// Notes:   Combinational; caller registers the result
`timescale 1ns/10ps
`default_nettype none
module cfd_alu (
    cfd_alu_if.alu bus
);
    logic       cin;
    logic [7:0] operand;
    logic [8:0] sum;

    // Subtract as dest + ~work + cin, cin = carry or 1 when ignored
    assign cin     = bus.carry_dis ? bus.is_sub
                                   : bus.carry;
    assign operand = bus.is_sub ? ~bus.work : bus.work;
    assign sum     = {1'b0, bus.dest} + {1'b0, operand}
                   + {8'h00, cin};
    assign bus.result    = sum[7:0];
    assign bus.carry_out = sum[8];
endmodule : cfd_alu
`default_nettype wire

// file: hw/cfd_insync.sv
// Purpose: Optional two-stage input synchroniser for port pins
// Assumes: Bypass setting is static while running
// Notes:   Bypassed path is combinational
`timescale 1ns/10ps
`default_nettype none
module cfd_insync #(
    parameter int PORT_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              bypass,
    input  wire logic [PORT_W-1:0] pin_in,
    output logic      [PORT_W-1:0] pin_out
);
    logic [PORT_W-1:0] meta;
    logic [PORT_W-1:0] stable;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta   <= '0;
            stable <= '0;
        end else begin
            meta   <= pin_in;
            stable <= meta;
        end
    end

    assign pin_out = bypass ? pin_in : stable;

    property p_sync_delay;
        @(posedge sys_clk) disable iff (!rst_n)
        (!bypass && $past(rst_n, 2)) |-> pin_out == $past(pin_in, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("synchronised port is not two cycles late");
endmodule : cfd_insync
`default_nettype wire

// file: test/cfd_prog_tool.sv
// Purpose: Programming tool model, one APB transfer per go request
// Assumes: Slave may add wait states; we wait on pready
// Notes:   Released address and data invert so nothing stale reads ok
`timescale 1ns/10ps
`default_nettype none
module cfd_prog_tool (
    input  wire logic        sys_clk,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             done,
    output logic      [31:0] rdata,
    output logic             err
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, done, rdata, err} = '0;
    end
    always @(posedge sys_clk) begin
        done <= 1'b0;
        if (psel && penable && pready) begin
            rdata   <= prdata;
            err     <= pslverr;
            done    <= 1'b1;
            psel    <= 1'b0;
            penable <= 1'b0;
            paddr   <= ~paddr;
            pwdata  <= ~pwdata;
        end else if (psel) begin
            penable <= 1'b1;
        end else if (go) begin
            psel   <= 1'b1;
            pwrite <= wr;
            paddr  <= addr;
            pwdata <= wdata;
        end
    end
endmodule : cfd_prog_tool
`default_nettype wire

// file: test/cfd_top_tb.sv
// Purpose: Self-checking bench for the configuration decoder
// Assumes: Words act only after a reset pulse
// Notes:   Row table packs main, ext and the expected decode
`timescale 1ns/10ps
`default_nettype none
module cfd_top_tb;
    logic sys_clk = 0, rst_n = 0, por_n = 0, go = 0, wr = 0;
    logic alu_carry = 0, alu_sub = 0;
    logic [7:0] addr = 0, alu_dest = 0, alu_work = 0, port_in = 0;
    logic [31:0] wdata = 0, pwdata, prdata, rdata;
    logic [7:0] paddr, port_in_sync, alu_result;
    logic psel, penable, pwrite, pready, pslverr, done, err;
    logic alu_carry_out, timer_readback_select, timer_edge_irq_enable;
    logic brownout_on, int_osc_on, instr_tick, ext_osc_rc, insync_on;
    logic osc_out_clock_on, crystal_buffer_on, read_scramble_on;
    logic watchdog_on, carry_in_disable;
    logic [3:0] stack_depth, data_banks;
    logic [2:0] prog_pages, int_osc_trim, ext_osc_type;
    logic [1:0] brownout_level_sel, brownout_trim, int_osc_divider;
    int n_fail = 0, total_checks = 0, cyc = 0;
    logic [3:0] ticks = 0;
    // Decode vector, same packing as the row table
    wire logic [21:0] dec = {stack_depth, prog_pages, data_banks,
        brownout_on, int_osc_on, ext_osc_rc, crystal_buffer_on,
        read_scramble_on, insync_on, brownout_level_sel, int_osc_trim};
    logic [45:0] rows [4] = '{
        {12'h000, 12'h000, 4'h8, 3'h1, 4'h1, 6'h33, 2'h0, 3'h0},
        {12'h287, 12'h411, 4'h2, 3'h1, 4'h2, 6'h2F, 2'h1, 3'h0},
        {12'h1C5, 12'h062, 4'h8, 3'h4, 4'h4, 6'h20, 2'h2, 3'h0},
        {12'h030, 12'hBB3, 4'h8, 3'h4, 4'h8, 6'h13, 2'h3, 3'h7}};
    cfd_top uut (.*);
    cfd_prog_tool tool (.*);
    always #25 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {go, wr, addr, wdata} <= {1'b1, w, a, d};
        @(posedge sys_clk);
        go <= 1'b0;
        // Wait for the answer; the cycle timeout ends a hang
        do begin
            @(posedge sys_clk);
            #1;
        end while (!done);
    endtask : apb
    task alu(input logic [7:0] d, w, input logic c, s, input logic [8:0] e);
        @(posedge sys_clk);
        {alu_dest, alu_work, alu_carry, alu_sub} <= {d, w, c, s};
        @(posedge sys_clk);
        #1;
        chk({alu_carry_out, alu_result}, 32'(e));
    endtask : alu
    task rst_pulse;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
    endtask : rst_pulse
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up;
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge sys_clk);
        {rst_n, por_n} <= 2'h3;
        @(posedge sys_clk);
        #1;
        chk(dec, {4'h2, 3'h4, 4'h8, 6'h10, 2'h3, 3'h0});
        chk(carry_in_disable, 1'b1);
        apb(1'b1, cfd_pkg::OFS_OPTION, 32'h0);
        chk({timer_edge_irq_enable, timer_readback_select}, 2'h3);
        alu(8'h10, 8'h01, 1'b1, 1'b0, 9'h011);
        alu(8'h10, 8'h01, 1'b0, 1'b1, 9'h10F);
        @(posedge sys_clk);
        port_in <= 8'h5A;
        #1;
        chk(port_in_sync, 8'h5A);
        for (int i = 0; i < 4; i++) begin
            // The tool supplies trim values 000 and 111 through the words
            apb(1'b1, cfd_pkg::OFS_WORD_MAIN, 32'(rows[i][45:34]));
            apb(1'b1, cfd_pkg::OFS_WORD_EXT, 32'(rows[i][33:22]));
            rst_pulse;
            chk(dec, rows[i][21:0]);
            if (rows[i][8]) chk(osc_out_clock_on, 1'b0);
        end
        chk(ext_osc_type, 3'h0);
        chk(int_osc_divider, 2'h3);
        apb(1'b1, cfd_pkg::OFS_OPTION, 32'h0);
        chk({timer_edge_irq_enable, timer_readback_select}, 2'h0);
        alu(8'h10, 8'h01, 1'b1, 1'b0, 9'h012);
        alu(8'h10, 8'h01, 1'b0, 1'b1, 9'h10E);
        @(posedge sys_clk);
        port_in <= 8'hA5;
        @(posedge sys_clk);
        #1;
        chk(port_in_sync, 8'h5A);
        @(posedge sys_clk);
        #1;
        chk(port_in_sync, 8'hA5);
        apb(1'b0, cfd_pkg::OFS_WORD_MAIN, 32'h0);
        chk(rdata, 32'h65C);
        apb(1'b0, 8'h10, 32'h0);
        chk({err, rdata}, {1'b1, 32'h0});
        // A new word must not leak into the decode before reset
        apb(1'b1, cfd_pkg::OFS_WORD_MAIN, 32'h287);
        @(posedge sys_clk);
        #1;
        chk(dec, rows[3][21:0]);
        // Watchdog, brown-out trim, mixed trim bits, 4 MHz tick spacing
        apb(1'b1, cfd_pkg::OFS_WORD_MAIN, 32'h008);
        apb(1'b1, cfd_pkg::OFS_WORD_EXT, 32'h90C);
        rst_pulse;
        chk({watchdog_on, brownout_trim, int_osc_trim}, 6'h3D);
        repeat (10) begin
            @(posedge sys_clk);
            #1;
            ticks += instr_tick;
        end
        chk(ticks, 2);
        wrap_up;
    end
endmodule : cfd_top_tb
`default_nettype wire
